// ===== rtl/bus_err_pkg.sv
package bus_err_pkg;

   // Core clock and node reset timing.
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned NODE_RST_NS     = 10_000;
   localparam int unsigned NODE_RST_CYCLES =
      (NODE_RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned RST_CNT_W       = 12;

   // Field positions of the bus error status register.
   localparam int unsigned ERROR_SUMMARY_BIT             = 31;
   localparam int unsigned NODE_RESET_CMD_BIT            = 30;
   localparam int unsigned NODE_HALT_RSVD_BIT            = 29;
   localparam int unsigned BUS_BAD_RSVD_BIT              = 28;
   localparam int unsigned CORRECTED_CONFIRM_ERR_BIT     = 27;
   localparam int unsigned BUS_TRIGGER_STATE_BIT         = 26;
   localparam int unsigned WRITE_ERR_INTR_RSVD_BIT       = 25;
   localparam int unsigned INCONSISTENT_PARITY_ERR_BIT   = 24;
   localparam int unsigned PARITY_ERR_BIT                = 23;
   localparam int unsigned WRITE_SEQUENCE_ERR_BIT        = 22;
   localparam int unsigned READ_IDENT_DATA_NOACK_BIT     = 21;
   localparam int unsigned WRITE_DATA_NOACK_BIT          = 20;
   localparam int unsigned CORRECTED_READ_DATA_BIT       = 19;
   localparam int unsigned NO_READ_RESPONSE_BIT          = 18;
   localparam int unsigned READ_SEQUENCE_ERR_BIT         = 17;
   localparam int unsigned READ_ERROR_RESPONSE_BIT       = 16;
   localparam int unsigned COMMAND_NOACK_BIT             = 15;
   localparam int unsigned TRANSACTION_TIMEOUT_BIT       = 13;
   localparam int unsigned NODE_SPECIFIC_ERR_SUMMARY_BIT = 12;
   localparam int unsigned SELFTEST_FAIL_BIT             = 10;
   localparam int unsigned CMDR_ID_LSB                   = 0;
   localparam int unsigned CMDR_ID_W                     = 4;

   // Masks and reset value.
   localparam logic [31:0] W1C_MASK      = 32'h0DFFB400;
   localparam logic [31:0] SUMMARY_MASK  = 32'h09FFB400;
   localparam logic [31:0] STATUS_RESET  = 32'h00000000;

   typedef logic [31:0]          word_t;
   typedef logic [CMDR_ID_W-1:0] cmdr_id_t;

   // One-cycle error events reported by the bus interface logic.
   typedef struct packed {
      logic     corrected_confirm_err;
      logic     inconsistent_parity_err;
      logic     parity_err;
      logic     write_sequence_err;
      logic     read_ident_data_noack;
      logic     write_data_noack;
      logic     corrected_read_data;
      logic     no_read_response;
      logic     read_sequence_err;
      logic     read_error_response;
      logic     command_noack;
      logic     transaction_timeout;
      logic     node_specific_err_summary;
      logic     selftest_fail;
      cmdr_id_t fail_cmdr_id;
   } err_evt_s;

   // Reset lines toward the companion module.
   typedef struct packed {
      logic companion_reset;
      logic secondary_ac_low_n;
      logic secondary_dc_low_n;
      logic busy;
   } node_rst_s;

endpackage

// ===== rtl/bus_error_status_reg.sv
`timescale 1ns/1ps
module bus_error_status_reg (
   // Clock and reset
   input  wire logic                  i_core_clk,
   input  wire logic                  i_resetn,
   // Register port
   input  wire logic                  i_reg_wr_en,
   input  wire logic                  i_reg_rd_en,
   input  wire bus_err_pkg::word_t    i_reg_wdata,
   output bus_err_pkg::word_t         o_reg_rdata,
   // Error events from the bus interface
   input  wire bus_err_pkg::err_evt_s i_err_evt,
   // Bus trigger pin
   input  wire logic                  i_bus_trigger,
   // Status
   output logic                       o_error_summary,
   output logic                       o_node_reset_busy,
   // Companion module reset lines
   output logic                       o_companion_reset,
   output logic                       o_secondary_ac_low_n,
   output logic                       o_secondary_dc_low_n
);

   typedef struct packed {
      bus_err_pkg::word_t    flags;
      bus_err_pkg::cmdr_id_t cmdr_id;
      logic                  id_locked;
      logic                  summary;
      bus_err_pkg::word_t    rdata;
   } core_state_s;

   core_state_s            state_reg;
   core_state_s            state_next;
   bus_err_pkg::node_rst_s node_rst;
   logic                   trigger_level;
   logic                   core_resetn;
   logic                   node_rst_start;
   bus_err_pkg::word_t     set_vec;
   bus_err_pkg::word_t     clr_vec;
   bus_err_pkg::word_t     flags_kept;
   logic                   any_fail;
   bus_err_pkg::word_t     read_word;

   pin_sync3 #(
      .WIDTH (1)
   ) u_trigger_sync (
      .i_core_clk (i_core_clk),
      .i_resetn   (core_resetn),
      .i_pin      (i_bus_trigger),
      .o_level    (trigger_level)
   );

   // The sequencer itself runs on the external reset only, otherwise the
   // reset period it generates would clear its own counter.
   node_reset_seq u_node_reset_seq (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .i_start    (node_rst_start),
      .o_rst      (node_rst)
   );

   assign node_rst_start =
      i_reg_wr_en & i_reg_wdata[bus_err_pkg::NODE_RESET_CMD_BIT];

   // reset of the whole block except the sequencer
   // The start strobe joins the reset so that the register is already
   // clear on the first cycle in which the reset lines are asserted.
   assign core_resetn = i_resetn & ~node_rst.busy & ~node_rst_start;

   // Map the one-cycle events onto their register positions.
   always_comb begin
      set_vec = '0;
      set_vec[bus_err_pkg::CORRECTED_CONFIRM_ERR_BIT] =
         i_err_evt.corrected_confirm_err;
      set_vec[bus_err_pkg::BUS_TRIGGER_STATE_BIT] = trigger_level;
      set_vec[bus_err_pkg::INCONSISTENT_PARITY_ERR_BIT] =
         i_err_evt.inconsistent_parity_err;
      set_vec[bus_err_pkg::PARITY_ERR_BIT] = i_err_evt.parity_err;
      set_vec[bus_err_pkg::WRITE_SEQUENCE_ERR_BIT] =
         i_err_evt.write_sequence_err;
      set_vec[bus_err_pkg::READ_IDENT_DATA_NOACK_BIT] =
         i_err_evt.read_ident_data_noack;
      set_vec[bus_err_pkg::WRITE_DATA_NOACK_BIT] =
         i_err_evt.write_data_noack;
      set_vec[bus_err_pkg::CORRECTED_READ_DATA_BIT] =
         i_err_evt.corrected_read_data;
      set_vec[bus_err_pkg::NO_READ_RESPONSE_BIT] =
         i_err_evt.no_read_response;
      set_vec[bus_err_pkg::READ_SEQUENCE_ERR_BIT] =
         i_err_evt.read_sequence_err;
      set_vec[bus_err_pkg::READ_ERROR_RESPONSE_BIT] =
         i_err_evt.read_error_response;
      set_vec[bus_err_pkg::COMMAND_NOACK_BIT] = i_err_evt.command_noack;
      set_vec[bus_err_pkg::TRANSACTION_TIMEOUT_BIT] =
         i_err_evt.transaction_timeout;
      set_vec[bus_err_pkg::NODE_SPECIFIC_ERR_SUMMARY_BIT] =
         i_err_evt.node_specific_err_summary;
      set_vec[bus_err_pkg::SELFTEST_FAIL_BIT] = i_err_evt.selftest_fail;
      if (node_rst.busy) begin
         set_vec = '0;
      end
   end

   // A failed transaction is any error event that names a commander; the
   // trigger line is a development aid and not a failure.
   assign any_fail =
      |(set_vec & bus_err_pkg::SUMMARY_MASK);

   // Write-one-to-clear applies only to the sticky flag positions.
   assign clr_vec = i_reg_wr_en ? (i_reg_wdata & bus_err_pkg::W1C_MASK)
                                : '0;

   // Software clears first and hardware sets afterwards, so an event in
   // the same cycle as its clear is kept.
   assign flags_kept = state_reg.flags & ~clr_vec;

   always_comb begin
      state_next = state_reg;
      state_next.flags = (flags_kept | set_vec) & bus_err_pkg::W1C_MASK;

      // The identifier is released once every summary flag is cleared.
      if ((flags_kept & bus_err_pkg::SUMMARY_MASK) == '0) begin
         state_next.id_locked = 1'b0;
      end
      if (any_fail && !state_reg.id_locked) begin
         state_next.cmdr_id   = i_err_evt.fail_cmdr_id;
         state_next.id_locked = 1'b1;
      end else if (any_fail && state_next.id_locked == 1'b0) begin
         state_next.cmdr_id   = i_err_evt.fail_cmdr_id;
         state_next.id_locked = 1'b1;
      end

      state_next.summary =
         |(state_next.flags & bus_err_pkg::SUMMARY_MASK);

      if (i_reg_rd_en) begin
         state_next.rdata = read_word;
      end
   end

   // Read view of the register as it stands before this cycle's update.
   always_comb begin
      read_word = state_reg.flags & bus_err_pkg::W1C_MASK;
      read_word[bus_err_pkg::ERROR_SUMMARY_BIT] =
         |(state_reg.flags & bus_err_pkg::SUMMARY_MASK);
      read_word[bus_err_pkg::NODE_RESET_CMD_BIT] = 1'b0;
      read_word[bus_err_pkg::NODE_HALT_RSVD_BIT]      = 1'b0;
      read_word[bus_err_pkg::BUS_BAD_RSVD_BIT]        = 1'b0;
      read_word[bus_err_pkg::WRITE_ERR_INTR_RSVD_BIT] = 1'b0;
      read_word[bus_err_pkg::CMDR_ID_LSB +: bus_err_pkg::CMDR_ID_W] =
         state_reg.cmdr_id;
   end

   always_ff @(posedge i_core_clk) begin
      if (!core_resetn) begin
         state_reg       <= '0;
         state_reg.flags <= bus_err_pkg::STATUS_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_reg_rdata          = state_reg.rdata;
   assign o_error_summary      = state_reg.summary;
   assign o_node_reset_busy    = node_rst.busy;
   assign o_companion_reset    = node_rst.companion_reset;
   assign o_secondary_ac_low_n = node_rst.secondary_ac_low_n;
   assign o_secondary_dc_low_n = node_rst.secondary_dc_low_n;

endmodule

// ===== rtl/node_reset_seq.sv
`timescale 1ns/1ps
// Stretches the node reset command into a fixed reset period. It is only
// cleared by the external reset, so the command cannot cut itself short.
module node_reset_seq (
   // Clock and reset
   input  wire logic                  i_core_clk,
   input  wire logic                  i_resetn,
   // Command
   input  wire logic                  i_start,
   // Reset lines
   output bus_err_pkg::node_rst_s     o_rst
);

   localparam logic [bus_err_pkg::RST_CNT_W-1:0] CNT_LOAD =
      bus_err_pkg::RST_CNT_W'(bus_err_pkg::NODE_RST_CYCLES);

   typedef struct packed {
      logic [bus_err_pkg::RST_CNT_W-1:0] cnt;
      bus_err_pkg::node_rst_s            rst;
   } seq_state_s;

   seq_state_s state_reg;
   seq_state_s state_next;

   always_comb begin
      state_next = state_reg;
      if (state_reg.rst.busy) begin
         if (state_reg.cnt == '0) begin
            state_next.rst.busy = 1'b0;
         end else begin
            state_next.cnt = state_reg.cnt - 1'b1;
         end
      end else if (i_start) begin
         state_next.rst.busy = 1'b1;
         state_next.cnt      = CNT_LOAD - 1'b1;
      end
      state_next.rst.companion_reset    = state_next.rst.busy;
      state_next.rst.secondary_ac_low_n = ~state_next.rst.busy;
      state_next.rst.secondary_dc_low_n = ~state_next.rst.busy;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         state_reg     <= '0;
         state_reg.rst <= 4'h6;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_rst = state_reg.rst;

endmodule

// ===== rtl/pin_sync3.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; output follows once stages two and three
// agree, which filters a single-cycle disagreement after metastability.
module pin_sync3 #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             i_core_clk,
   input  wire logic             i_resetn,
   // Pin side
   input  wire logic [WIDTH-1:0] i_pin,
   // Core side
   output logic      [WIDTH-1:0] o_level
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] level;
   } sync_state_s;

   sync_state_s state_reg;
   sync_state_s state_next;

   always_comb begin
      state_next    = state_reg;
      state_next.s1 = i_pin;
      state_next.s2 = state_reg.s1;
      state_next.s3 = state_reg.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (state_reg.s2[i] == state_reg.s3[i]) begin
            state_next.level[i] = state_reg.s3[i];
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_level = state_reg.level;

endmodule

// ===== verification/bus_err_partner.sv
`timescale 1ns/1ps
// Other bus nodes: one failure per request as a single-cycle event.
module bus_err_partner (
   // Clock
   input  wire logic                  i_core_clk,
   // Requests from the bench
   input  wire logic                  i_go,
   input  wire logic [3:0]            i_sel,
   input  wire bus_err_pkg::cmdr_id_t i_id,
   input  wire logic                  i_trig,
   // Toward the block
   output bus_err_pkg::err_evt_s      o_err_evt,
   output logic                       o_trigger
);
   initial begin
      o_err_evt = '0;
      o_trigger = 1'b0;
   end
   // The identifier is only valid with an event, so it toggles otherwise.
   always @(posedge i_core_clk) begin
      o_err_evt <= {14'h0000, ~o_err_evt.fail_cmdr_id};
      o_trigger <= i_trig;
      if (i_go) begin
         o_err_evt[17 - i_sel] <= 1'b1;
         o_err_evt.fail_cmdr_id <= i_id;
      end
   end
endmodule

// ===== verification/bus_error_status_reg_asserts.sv
`timescale 1ns/1ps
module bus_error_status_reg_asserts (
   // Clock and reset
   input wire logic                  i_core_clk,
   input wire logic                  i_resetn,
   // Register port and events
   input wire logic                  i_reg_wr_en,
   input wire logic                  i_reg_rd_en,
   input wire bus_err_pkg::word_t    i_reg_wdata,
   input wire bus_err_pkg::word_t    o_reg_rdata,
   input wire bus_err_pkg::err_evt_s i_err_evt,
   input wire logic                  i_bus_trigger,
   // Status and reset lines
   input wire logic                  o_error_summary,
   input wire logic                  o_node_reset_busy,
   input wire logic                  o_companion_reset,
   input wire logic                  o_secondary_ac_low_n,
   input wire logic                  o_secondary_dc_low_n
);
   logic [11:0] busy_cnt_reg;
   logic [11:0] busy_cnt_next;
   always_comb begin
      busy_cnt_next = o_node_reset_busy ? busy_cnt_reg + 12'h001 : 12'h000;
   end
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         busy_cnt_reg <= 12'h000;
      end else begin
         busy_cnt_reg <= busy_cnt_next;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   a_rsvd_read_zero: assert property (
      (o_reg_rdata & 32'h32000000) == 32'h00000000)
      else $error("reserved bits read nonzero");
   a_node_reset_cmd_reads_zero: assert property (!o_reg_rdata[30])
      else $error("node reset bit reads one");
   a_summary_or: assert property (
      o_reg_rdata[31] == |(o_reg_rdata & bus_err_pkg::SUMMARY_MASK))
      else $error("summary bit differs from flag OR");
   a_evt_sets_sum: assert property (
      |i_err_evt[17:4] && !o_node_reset_busy && !i_reg_wr_en
      |=> o_error_summary) else $error("event did not set summary");
   a_status_holds: assert property (
      o_error_summary && !i_reg_wr_en |=> o_error_summary)
      else $error("status dropped without a clear");
   a_node_reset_cmd_start: assert property (
      i_reg_wr_en && i_reg_wdata[30] && !o_node_reset_busy
      |=> o_node_reset_busy) else $error("node reset did not start");
   a_node_reset_cmd_length: assert property (
      $fell(o_node_reset_busy)
      |-> busy_cnt_reg == 12'(bus_err_pkg::NODE_RST_CYCLES))
      else $error("node reset period wrong");
   a_rst_lines: assert property (
      o_companion_reset == o_node_reset_busy
      && o_secondary_ac_low_n == !o_node_reset_busy
      && o_secondary_dc_low_n == !o_node_reset_busy)
      else $error("companion reset lines wrong");
   a_node_reset_cmd_clears: assert property (
      o_node_reset_busy |-> !o_error_summary && o_reg_rdata == 32'h00000000)
      else $error("state not cleared in node reset");
   c_node_reset_cmd: cover property ($rose(o_node_reset_busy));
   c_summary: cover property ($rose(o_error_summary));
   c_read_err: cover property (i_reg_rd_en && o_error_summary);
endmodule
bind bus_error_status_reg bus_error_status_reg_asserts u_chk (
   .i_core_clk, .i_resetn, .i_reg_wr_en, .i_reg_rd_en, .i_reg_wdata,
   .o_reg_rdata, .i_err_evt, .i_bus_trigger, .o_error_summary,
   .o_node_reset_busy, .o_companion_reset, .o_secondary_ac_low_n,
   .o_secondary_dc_low_n);

// ===== verification/bus_error_status_reg_tb.sv
`timescale 1ns/1ps
module bus_error_status_reg_tb;
   logic                  clk;
   logic                  rst_n;
   logic                  wr_en;
   logic                  rd_en;
   bus_err_pkg::word_t    wdata;
   bus_err_pkg::word_t    rdata;
   bus_err_pkg::err_evt_s err_evt;
   logic                  trigger;
   logic                  summary;
   logic [3:0]            lines;
   logic                  evt_go;
   logic [3:0]            evt_sel;
   bus_err_pkg::cmdr_id_t evt_id;
   logic                  trig_req;
   int                    error_cnt;
   int                    num_checks;
   int                    cycle_cnt;
   int                    n;
   int unsigned           flag_bit [14] =
      '{27, 24, 23, 22, 21, 20, 19, 18, 17, 16, 15, 13, 12, 10};
   bus_error_status_reg u_bus_error_status_reg (
      .i_core_clk(clk), .i_resetn(rst_n), .i_reg_wr_en(wr_en),
      .i_reg_rd_en(rd_en), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_err_evt(err_evt), .i_bus_trigger(trigger),
      .o_error_summary(summary), .o_node_reset_busy(lines[3]),
      .o_companion_reset(lines[2]), .o_secondary_ac_low_n(lines[1]),
      .o_secondary_dc_low_n(lines[0]));
   bus_err_partner u_bus_err_partner (
      .i_core_clk(clk), .i_go(evt_go), .i_sel(evt_sel), .i_id(evt_id),
      .i_trig(trig_req), .o_err_evt(err_evt), .o_trigger(trigger));
   task automatic check(input bus_err_pkg::word_t got, exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic write_reg(input bus_err_pkg::word_t d);
      @(posedge clk);
      wr_en <= 1'b1;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic read_chk(input bus_err_pkg::word_t exp);
      @(posedge clk);
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 check(rdata, exp);
   endtask
   task automatic raise(input int k, input bus_err_pkg::cmdr_id_t id);
      @(posedge clk);
      evt_go <= 1'b1;
      evt_sel <= 4'(k);
      evt_id <= id;
      @(posedge clk);
      evt_go <= 1'b0;
      @(posedge clk);
   endtask
   task automatic t_flags();
      for (int k = 0; k < 14; k++) begin
         raise(k, 4'(k + 1));
         read_chk(32'h80000000 | (32'h1 << flag_bit[k]) | 32'(k + 1));
         write_reg(32'h1 << flag_bit[k]);
         // The identifier outlives the clear; only a new failure replaces it.
         read_chk(32'(k + 1));
      end
      $display("test flags done");
   endtask
   task automatic t_hold();
      raise(2, 4'h5);
      raise(10, 4'h9);
      read_chk(32'h80808005);
      check(32'(summary), 32'h1);
      write_reg(32'hB24003FF);
      read_chk(32'h80808005);
      write_reg(32'h00808000);
      read_chk(32'h00000005);
      check(32'(summary), 32'h0);
      $display("test hold done");
   endtask
   task automatic t_trigger();
      @(posedge clk);
      trig_req <= 1'b1;
      repeat (6) @(posedge clk);
      trig_req <= 1'b0;
      repeat (5) @(posedge clk);
      read_chk(32'h04000005);
      write_reg(32'h04000000);
      read_chk(32'h00000005);
      $display("test trigger done");
   endtask
   task automatic t_node_reset();
      raise(0, 4'h3);
      write_reg(32'h40000000);
      @(posedge clk);
      #1 check(32'(lines), 32'hC);
      // Busy has stood through the edge that took the write and this one.
      n = 2;
      while (lines[3] === 1'b1 && n < 1000) begin
         @(posedge clk);
         #1 n += (lines[3] === 1'b1) ? 1 : 0;
      end
      check(32'(n), bus_err_pkg::NODE_RST_CYCLES);
      check(32'(lines), 32'h3);
      check(32'(summary), 32'h0);
      read_chk(32'h00000000);
      $display("test node reset done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // The full run needs under a thousand cycles; the ceiling leaves margin.
   always @(posedge clk) begin
      cycle_cnt++;
      if (cycle_cnt == 4000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   initial begin
      {rst_n, wr_en, rd_en, wdata, evt_go, evt_sel, evt_id} = '0;
      trig_req = 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      read_chk(32'h00000000);
      t_flags();
      t_hold();
      t_trigger();
      t_node_reset();
      report_and_stop();
   end
endmodule
